// *** src/e1sb_defines.svh ***
// Offsets, page codes, reset values and sizes of the spare-bit and message buffers.
`ifndef E1SB_DEFINES_SVH
`define E1SB_DEFINES_SVH
// Page codes of the paged register port.
`define E1SB_PAGE_TX_SPARE  8'h0d
`define E1SB_PAGE_RX_SPARE  8'h0e
`define E1SB_PAGE_TX_MSG_LO 8'h0f
`define E1SB_PAGE_TX_MSG_HI 8'h10
`define E1SB_PAGE_RX_MSG_LO 8'h11
`define E1SB_PAGE_RX_MSG_HI 8'h12
// Offsets inside a page.
`define E1SB_SPARE_FIRST    5'h10
`define E1SB_SPARE_LAST     5'h14
`define E1SB_MSG_FIRST      5'h10
`define E1SB_MSG_LAST       5'h1f
// Line positions: channel zero, first spare bit position (bit 4 of 1..8).
`define E1SB_SLOT_ZERO      5'h00
`define E1SB_SPARE_BITPOS   3'h3
`define E1SB_LAST_BITPOS    3'h7
// Buffer sizes and reset value.
`define E1SB_SPARE_BYTES    5
`define E1SB_SLOTS          32
`define E1SB_FIFO_DEPTH     16
`define E1SB_RESET_BYTE     8'h00
`endif

// *** src/e1sb_pkg.sv ***
// Types shared by the spare-bit and message buffer block.
package e1sb_pkg;
	// One register port request, sampled each clock.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] page;
		logic [4:0] addr;
		logic [7:0] wdata;
	} e1sb_cpu_t;
	// Position of the current bit on one direction of the line.
	typedef struct packed {
		logic       strobe;
		logic [3:0] frame;
		logic [4:0] slot;
		logic [2:0] bitpos;
	} e1sb_pos_t;
	// A received timeslot byte on its way to the message buffer.
	typedef struct packed {
		logic [4:0] slot;
		logic [7:0] data;
	} e1sb_msg_t;
	// Register regions selected by page and offset.
	typedef enum logic [2:0] {
		E1SB_REG_NONE,
		E1SB_REG_TX_SPARE,
		E1SB_REG_RX_SPARE,
		E1SB_REG_TX_MSG,
		E1SB_REG_RX_MSG
	} e1sb_region_t;
endpackage

// *** src/e1sb_buffers.sv ***
// Spare-bit buffers, message buffers and their receive FIFO.
`timescale 1ns/10ps
`include "e1sb_defines.svh"

// Simple synchronous FIFO with valid and ready on both sides.
module e1sb_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = `E1SB_FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [CW-1:0]    count_q;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (count_q != CNT_FULL);
	assign out_valid = (count_q != '0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage is written only on an accepted push.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers wrap at the configured depth, which need not be a power of two.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	// Occupancy count.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + 1'b1;
		end else if (pop && !push) begin
			count_q <= count_q - 1'b1;
		end
	end
endmodule // e1sb_fifo

// Behaviour
// - Five writable transmit spare-bit bytes sit at offsets 10H to 14H of page 0DH.
// - Transmit spare bits reach the line only while the spare-bit transmit enable is one.
// - Transmit spare byte n feeds bit n+4 of channel zero, bit 7 first, over frames 1 to 15 with CRC-4 or over consecutive odd frames without.
// - Five readable receive spare-bit bytes sit at offsets 10H to 14H of page 0EH.
// - Receive spare byte n captures bit n+4 of received channel zero over frames 1 to 15 with CRC-4 or over consecutive odd frames without.
// - Thirty-two transmit message bytes, one per line timeslot, are held across pages 0FH and 10H.
// - A timeslot sends its message byte instead of normal data only when its message-select bit is set.
// - Page 0FH offsets 10H to 1FH hold the transmit message bytes of timeslots 0 to 15.
// - Page 10H offsets 10H to 1FH hold the transmit message bytes of timeslots 16 to 31.
// - Every receive message byte that finds room in the receive FIFO is refreshed once each frame from its received channel.
// - Receive message bytes come from the incoming line data, not from the backplane.
// - Page 11H offsets 10H to 1FH hold the received bytes of timeslots 0 to 15.
// - Page 12H offsets 10H to 1FH hold the received bytes of timeslots 16 to 31.
module e1sb_buffers
	import e1sb_pkg::*;
#(
	parameter int FIFO_DEPTH = `E1SB_FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Paged register port.
	input  wire e1sb_cpu_t   cpu_req,
	output logic      [7:0]  cpu_rdata,
	output logic             cpu_rvalid,
	// Controls held elsewhere in the framer.
	input  wire logic        spare_bit_tx_enable,
	input  wire logic        crc4_align,
	input  wire logic [31:0] message_slot_select,
	// Transmit line side.
	input  wire e1sb_pos_t   tx_pos,
	input  wire logic        tx_data_bit,
	output logic             tx_line_bit,
	// Receive line side.
	input  wire e1sb_pos_t   rx_pos,
	input  wire logic        rx_line_bit,
	output logic             msg_fifo_ready
);
	localparam int MSG_W = $bits(e1sb_msg_t);

	// Maps a page and offset onto the region it selects.
	function automatic e1sb_region_t region_of(input logic [7:0] page,
	                                           input logic [4:0] addr);
		logic spare_ok;
		logic msg_ok;
		spare_ok = (addr >= `E1SB_SPARE_FIRST) && (addr <= `E1SB_SPARE_LAST);
		msg_ok   = (addr >= `E1SB_MSG_FIRST) && (addr <= `E1SB_MSG_LAST);
		if (page == `E1SB_PAGE_TX_SPARE && spare_ok) begin
			return E1SB_REG_TX_SPARE;
		end else if (page == `E1SB_PAGE_RX_SPARE && spare_ok) begin
			return E1SB_REG_RX_SPARE;
		end else if ((page == `E1SB_PAGE_TX_MSG_LO ||
		              page == `E1SB_PAGE_TX_MSG_HI) && msg_ok) begin
			return E1SB_REG_TX_MSG;
		end else if ((page == `E1SB_PAGE_RX_MSG_LO ||
		              page == `E1SB_PAGE_RX_MSG_HI) && msg_ok) begin
			return E1SB_REG_RX_MSG;
		end else begin
			return E1SB_REG_NONE;
		end
	endfunction

	// Byte storage.
	logic [7:0] tx_spare_bits_byte_q [`E1SB_SPARE_BYTES];
	logic [7:0] rx_spare_bits_byte_q [`E1SB_SPARE_BYTES];
	logic [7:0] tx_msg_q             [`E1SB_SLOTS];
	logic [7:0] rx_msg_q             [`E1SB_SLOTS];

	e1sb_region_t cpu_region;
	logic [4:0]   msg_index;
	logic [2:0]   spare_index;
	logic [2:0]   tx_odd_cnt_q;
	logic [2:0]   rx_odd_cnt_q;
	logic [2:0]   tx_frame_idx;
	logic [2:0]   rx_frame_idx;
	logic         tx_in_spare;
	logic         rx_in_spare;
	logic [2:0]   tx_spare_n;
	logic [2:0]   rx_spare_n;
	logic [6:0]   rx_shift_q;
	logic         push_valid_q;
	e1sb_msg_t    push_data_q;
	logic         drain_valid;
	logic         drain_ready;
	e1sb_msg_t    drain_data;

	// Request decode; the high message pages add sixteen to the slot index.
	assign cpu_region  = region_of(cpu_req.page, cpu_req.addr);
	assign msg_index   = {(cpu_req.page == `E1SB_PAGE_TX_MSG_HI ||
	                       cpu_req.page == `E1SB_PAGE_RX_MSG_HI),
	                      cpu_req.addr[3:0]};
	assign spare_index = cpu_req.addr[2:0];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `E1SB_SPARE_BYTES; i++) begin
				tx_spare_bits_byte_q[i] <= `E1SB_RESET_BYTE;
			end
		end else if (cpu_req.wr && cpu_region == E1SB_REG_TX_SPARE) begin
			tx_spare_bits_byte_q[spare_index] <= cpu_req.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `E1SB_SLOTS; i++) begin
				tx_msg_q[i] <= `E1SB_RESET_BYTE;
			end
		end else if (cpu_req.wr && cpu_region == E1SB_REG_TX_MSG) begin
			tx_msg_q[msg_index] <= cpu_req.wdata;
		end
	end

	// Read data is registered and answered one cycle after the strobe.
	// spare and message read.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cpu_rdata  <= 8'h00;
			cpu_rvalid <= 1'b0;
		end else begin
			cpu_rvalid <= cpu_req.rd;
			if (cpu_req.rd) begin
				case (cpu_region)
					E1SB_REG_TX_SPARE: cpu_rdata <= tx_spare_bits_byte_q[spare_index];
					E1SB_REG_RX_SPARE: cpu_rdata <= rx_spare_bits_byte_q[spare_index];
					E1SB_REG_TX_MSG:   cpu_rdata <= tx_msg_q[msg_index];
					E1SB_REG_RX_MSG:   cpu_rdata <= rx_msg_q[msg_index];
					default:           cpu_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Spare-bit window: channel zero of an odd frame, bit positions 4 to 8.
	assign tx_in_spare = tx_pos.slot == `E1SB_SLOT_ZERO && tx_pos.frame[0] &&
	                     tx_pos.bitpos >= `E1SB_SPARE_BITPOS;
	assign rx_in_spare = rx_pos.slot == `E1SB_SLOT_ZERO && rx_pos.frame[0] &&
	                     rx_pos.bitpos >= `E1SB_SPARE_BITPOS;
	assign tx_spare_n  = tx_pos.bitpos - `E1SB_SPARE_BITPOS;
	assign rx_spare_n  = rx_pos.bitpos - `E1SB_SPARE_BITPOS;

	assign tx_frame_idx = crc4_align ? tx_pos.frame[3:1] : tx_odd_cnt_q;
	assign rx_frame_idx = crc4_align ? rx_pos.frame[3:1] : rx_odd_cnt_q;

	// Without multiframe alignment, odd frames are counted after channel zero.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_odd_cnt_q <= 3'h0;
			rx_odd_cnt_q <= 3'h0;
		end else begin
			if (tx_pos.strobe && tx_in_spare &&
			    tx_pos.bitpos == `E1SB_LAST_BITPOS) begin
				tx_odd_cnt_q <= tx_odd_cnt_q + 1'b1;
			end
			if (rx_pos.strobe && rx_in_spare &&
			    rx_pos.bitpos == `E1SB_LAST_BITPOS) begin
				rx_odd_cnt_q <= rx_odd_cnt_q + 1'b1;
			end
		end
	end

	// Transmit bit selection, registered on each bit strobe.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_line_bit <= 1'b0;
		end else if (tx_pos.strobe) begin
			if (spare_bit_tx_enable && tx_in_spare) begin
				tx_line_bit <= tx_spare_bits_byte_q[tx_spare_n][3'h7 - tx_frame_idx];
			end else if (message_slot_select[tx_pos.slot]) begin
				tx_line_bit <= tx_msg_q[tx_pos.slot][3'h7 - tx_pos.bitpos];
			end else begin
				tx_line_bit <= tx_data_bit;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `E1SB_SPARE_BYTES; g++) begin : g_rx_spare
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					rx_spare_bits_byte_q[g] <= `E1SB_RESET_BYTE;
				end else if (rx_pos.strobe && rx_in_spare &&
				             rx_spare_n == 3'(g)) begin
					rx_spare_bits_byte_q[g][3'h7 - rx_frame_idx] <= rx_line_bit;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_shift_q   <= 7'h00;
			push_valid_q <= 1'b0;
			push_data_q  <= '0;
		end else begin
			push_valid_q <= 1'b0;
			if (rx_pos.strobe) begin
				rx_shift_q <= {rx_shift_q[5:0], rx_line_bit};
				if (rx_pos.bitpos == `E1SB_LAST_BITPOS) begin
					push_valid_q     <= 1'b1;
					push_data_q.slot <= rx_pos.slot;
					push_data_q.data <= {rx_shift_q, rx_line_bit};
				end
			end
		end
	end

	// Drain stalls while software reads the receive message pages.
	assign drain_ready = !(cpu_req.rd && cpu_region == E1SB_REG_RX_MSG);

	// Received bytes pass through the FIFO; a byte met by a full FIFO is lost.
	e1sb_fifo #(
		.WIDTH (MSG_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (push_valid_q),
		.in_ready  (msg_fifo_ready),
		.in_data   (push_data_q),
		.out_valid (drain_valid),
		.out_ready (drain_ready),
		.out_data  (drain_data)
	);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `E1SB_SLOTS; i++) begin
				rx_msg_q[i] <= `E1SB_RESET_BYTE;
			end
		end else if (drain_valid && drain_ready) begin
			rx_msg_q[drain_data.slot] <= drain_data.data;
		end
	end
endmodule // e1sb_buffers

// *** testbench/e1sb_line_model.sv ***
// Line framing partner: bit positions and a received line stream.
`timescale 1ns/10ps
module e1sb_line_model
	import e1sb_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Control and line side.
	input  wire logic run,
	output e1sb_pos_t pos,
	output logic      rx_bit,
	output logic      frame_end
);
	logic [7:0] rbyte;
	// Byte carried by a received slot depends on frame and slot.
	assign rbyte = {pos.frame, 4'ha} ^ {pos.slot, 3'h0};
	assign rx_bit = pos.strobe ? rbyte[3'h7 - pos.bitpos]
		: ~rbyte[3'h7 - pos.bitpos];
	// Marks the strobe of the last bit of every frame.
	assign frame_end = pos.strobe && (&{pos.slot, pos.bitpos});
	// One strobe every second cycle, then step to the next bit.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pos <= '0;
		end else if (pos.strobe) begin
			pos.strobe <= 1'b0;
			{pos.frame, pos.slot, pos.bitpos} <=
				{pos.frame, pos.slot, pos.bitpos} + 12'h001;
		end else begin
			pos.strobe <= run;
		end
	end
endmodule // e1sb_line_model

// *** testbench/e1sb_chk.sv ***
// Port relations of the spare-bit and message buffers.
`timescale 1ns/10ps
module e1sb_chk
	import e1sb_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Watched ports.
	input wire e1sb_cpu_t   cpu_req,
	input wire logic [7:0]  cpu_rdata,
	input wire logic        cpu_rvalid,
	input wire logic        spare_bit_tx_enable,
	input wire logic [31:0] message_slot_select,
	input wire e1sb_pos_t   tx_pos,
	input wire logic        tx_data_bit,
	input wire logic        tx_line_bit
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Strobe of channel zero without message select.
	sequence s_z0;
		tx_pos.strobe && tx_pos.slot == 5'h00 && !message_slot_select[0];
	endsequence
	// Strobe of another slot without message select.
	sequence s_plain;
		tx_pos.strobe && tx_pos.slot != 5'h00
			&& !message_slot_select[tx_pos.slot];
	endsequence
	a_read_answer: assert property (cpu_req.rd |=> cpu_rvalid)
		else $error("read had no answer");
	a_no_stray: assert property (!cpu_req.rd |=> !cpu_rvalid)
		else $error("answer without read");
	a_rdata_holds: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (cpu_req.rd && cpu_req.page > 8'h12
		|=> cpu_rdata == 8'h00) else $error("unmapped read not zero");
	a_plain_data: assert property (s_plain
		|=> tx_line_bit == $past(tx_data_bit)) else $error("bad plain bit");
	a_spare_gate: assert property (s_z0 ##0 !spare_bit_tx_enable
		|=> tx_line_bit == $past(tx_data_bit)) else $error("spare leak");
	a_even_frame: assert property (s_z0 ##0 !tx_pos.frame[0]
		|=> tx_line_bit == $past(tx_data_bit)) else $error("even frame");
	a_line_stands: assert property (!tx_pos.strobe
		|=> $stable(tx_line_bit)) else $error("line bit moved");
endmodule // e1sb_chk

bind e1sb_buffers e1sb_chk u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
	.spare_bit_tx_enable(spare_bit_tx_enable),
	.message_slot_select(message_slot_select), .tx_pos(tx_pos),
	.tx_data_bit(tx_data_bit), .tx_line_bit(tx_line_bit));

// *** testbench/tb_e1_spare_bit_and_message_buffers.sv ***
// Self-checking bench of the spare-bit and message buffers.
`timescale 1ns/10ps
module tb_e1_spare_bit_and_message_buffers import e1sb_pkg::*;;
	logic        clk_sys = 0, rstn = 0, en = 0, run = 0, chk_q = 0;
	logic        crc4 = 1, line_rstn = 0, fifo_rdy;
	logic        tx_data_bit, tx_line_bit, cpu_rvalid, rx_bit, frame_end, exp_q;
	logic [2:0]  odd_q = 0, fidx;
	logic [7:0]  cpu_rdata, tx_spare [5], tx_msg [32];
	logic [31:0] sel = 32'h0010_0020;
	e1sb_cpu_t   cpu_req = '0;
	e1sb_pos_t   pos;
	int          errors = 0, n_tests = 0, cyc = 0;
	// Clock and a normal data pattern on the transmit side.
	always #10 clk_sys = ~clk_sys;
	assign tx_data_bit = pos.slot[1] ^ pos.bitpos[0] ^ pos.frame[1];
	e1sb_line_model u_line (.clk_sys(clk_sys), .rstn(line_rstn), .run(run),
		.pos(pos), .rx_bit(rx_bit), .frame_end(frame_end));
	e1sb_buffers u_dut (.clk_sys(clk_sys), .rstn(rstn), .cpu_req(cpu_req),
		.cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
		.spare_bit_tx_enable(en), .crc4_align(crc4),
		.message_slot_select(sel), .tx_pos(pos), .tx_data_bit(tx_data_bit),
		.tx_line_bit(tx_line_bit), .rx_pos(pos), .rx_line_bit(rx_bit),
		.msg_fifo_ready(fifo_rdy));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Transmit line monitor, expected bit taken one cycle ahead of its check, then the run's timeout.
	always @(posedge clk_sys) begin
		cyc++;
		if (chk_q) check({7'h0, tx_line_bit}, {7'h0, exp_q});
		chk_q = pos.strobe;
		fidx = crc4 ? pos.frame[3:1] : odd_q;
		if (en && pos.slot == 5'h00 && pos.frame[0] && pos.bitpos >= 3'h3)
			exp_q = tx_spare[pos.bitpos - 3'h3][3'h7 - fidx];
		else if (sel[pos.slot]) exp_q = tx_msg[pos.slot][3'h7 - pos.bitpos];
		else exp_q = tx_data_bit;
		// Odd frames are counted from reset for the unaligned mode.
		if (!rstn) odd_q = 3'h0;
		else if (pos.strobe && pos.slot == 5'h00 && pos.frame[0]
			&& pos.bitpos == 3'h7) odd_q = odd_q + 3'h1;
		if (cyc > 60000) begin errors++; give_verdict(); end
	end
	task automatic acc(input logic w, input logic [7:0] pg,
		input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys); #1;
		cpu_req = '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
		@(posedge clk_sys); #1;
		cpu_req = '0;
	endtask
	task automatic rd_chk(input logic [7:0] pg, input logic [4:0] a,
		input logic [7:0] exp);
		acc(1'b0, pg, a, 8'h00);
		check({7'h0, cpu_rvalid}, 8'h01);
		check(cpu_rdata, exp);
	endtask
	task automatic run_mf(input int n, input logic e);
		@(posedge clk_sys); #1;
		en = e;
		run = 1;
		for (int k = 0; k < 20000 && n > 0; k++) begin
			@(posedge clk_sys); #1;
			if (frame_end) n--;
		end
		run = 0;
		check(8'(n), 8'h00);
		repeat (40) @(posedge clk_sys);
	endtask
	function automatic logic [7:0] rbyte(input logic [3:0] f,
		input logic [4:0] s);
		return {f, 4'ha} ^ {s, 3'h0};
	endfunction
	function automatic logic [7:0] sp_exp(input int n,
		input logic [3:0] first);
		logic [7:0] v, b;
		for (int k = 0; k < 8; k++) begin
			b = rbyte(4'(first + 2 * k), 5'h00);
			v[7 - k] = b[4 - n];
		end
		return v;
	endfunction
	// Register map: writable, read-only and unmapped places.
	task automatic t_regs;
		for (int i = 0; i < 5; i++) begin
			tx_spare[i] = 8'h3c ^ 8'(i * 37);
			acc(1'b1, 8'h0d, 5'(16 + i), tx_spare[i]);
			acc(1'b1, 8'h0e, 5'(16 + i), 8'hff);
		end
		for (int i = 0; i < 32; i++) begin
			tx_msg[i] = 8'(i * 29 + 1);
			acc(1'b1, 8'h0f + 8'(i / 16), 5'(16 + i % 16), tx_msg[i]);
		end
		for (int i = 0; i < 5; i++) begin
			rd_chk(8'h0d, 5'(16 + i), tx_spare[i]);
			rd_chk(8'h0e, 5'(16 + i), 8'h00);
		end
		for (int i = 0; i < 32; i++)
			rd_chk(8'h0f + 8'(i / 16), 5'(16 + i % 16), tx_msg[i]);
		rd_chk(8'h13, 5'h10, 8'h00);
		acc(1'b1, 8'h11, 5'h10, 8'hff);
		rd_chk(8'h11, 5'h10, 8'h00);
		check({7'h0, fifo_rdy}, 8'h01);
		$display("test regs done");
	endtask
	// Line traffic with spare insertion on, then receive buffers read.
	task automatic t_line;
		run_mf(32, 1'b1);
		for (int s = 0; s < 32; s++)
			rd_chk(8'h11 + 8'(s / 16), 5'(16 + s % 16), rbyte(4'hf, 5'(s)));
		for (int n = 0; n < 5; n++)
			rd_chk(8'h0e, 5'(16 + n), sp_exp(n, 4'h1));
		run_mf(16, 1'b0);
		$display("test line done");
	endtask
	// Unaligned mode: a reset mid-multiframe restarts the odd-frame count.
	task automatic t_nocrc;
		#1 crc4 = 1'b0;
		run_mf(3, 1'b0);
		@(posedge clk_sys); #1;
		rstn = 0;
		repeat (2) @(posedge clk_sys);
		#1 rstn = 1;
		check({7'h0, fifo_rdy}, 8'h01);
		rd_chk(8'h0d, 5'h10, 8'h00);
		for (int i = 0; i < 32; i++) tx_msg[i] = 8'h00;
		for (int i = 0; i < 5; i++) begin
			tx_spare[i] = 8'ha5 ^ 8'(i * 19);
			acc(1'b1, 8'h0d, 5'(16 + i), tx_spare[i]);
		end
		run_mf(16, 1'b1);
		for (int n = 0; n < 5; n++)
			rd_chk(8'h0e, 5'(16 + n), sp_exp(n, 4'h3));
		rd_chk(8'h12, 5'h1f, rbyte(4'h2, 5'h1f));
		$display("test no crc done");
	endtask
	// Reset, scenarios and verdict.
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 rstn = 1;
		line_rstn = 1;
		t_regs();
		t_line();
		t_nocrc();
		give_verdict();
	end
endmodule // tb_e1_spare_bit_and_message_buffers
